//--- verilog/rsx_pkg.sv
// Package with opcodes, widths and reset values for the rotate, subtract and sleep executor.
`default_nettype none
package rsx_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 6;
  localparam int SADDR_W = 4;
  localparam int SFR_DEPTH = 16;
  localparam int FILE_DEPTH = 64;
  localparam int OP_W = 3;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] ROTATE_RIGHT_CARRY_OP = 3'h1;
  localparam logic [2:0] SUB_BORROW_REG_OP = 3'h2;
  localparam logic [2:0] SUB_BORROW_IMM_OP = 3'h3;
  localparam logic [2:0] STORE_SECONDARY_PAGE_OP = 3'h4;
  localparam logic [2:0] LOAD_SECONDARY_PAGE_OP = 3'h5;
  localparam logic [2:0] SLEEP_OP = 3'h6;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int MSB = 7;
  localparam int NIB = 4;
  typedef enum logic [1:0] {
    RSX_RUN = 2'b01,
    RSX_HALT = 2'b10
  } rsx_state_t;
endpackage : rsx_pkg
`default_nettype wire

//--- verilog/rsx_sub_unit.sv
// Subtract-with-borrow datapath that produces the result and the zero, digit-carry and carry flags.
`default_nettype none
module rsx_sub_unit (
  input wire logic [7:0] minuend_in,
  input wire logic [7:0] acc_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output logic zero_out,
  output logic digit_carry_out,
  output logic carry_out
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  always_comb begin
    sum = {1'b0, minuend_in} + {1'b0, ~acc_in} + {8'h00, carry_in};
    low_sum = {1'b0, minuend_in[3:0]} + {1'b0, ~acc_in[3:0]} + {4'h0, carry_in};
    result_out = sum[7:0];
    zero_out = (sum[7:0] == rsx_pkg::ZERO_BYTE);
    digit_carry_out = low_sum[rsx_pkg::NIB];
    carry_out = sum[rsx_pkg::DATA_W];
  end
endmodule : rsx_sub_unit
`default_nettype wire

//--- verilog/rsx_exec.sv
// Executor for rotate-right, subtract-with-borrow, secondary-page moves and the sleep instruction.
`default_nettype none
// Overview of operation
// - Rotate right moves the old carry into bit 7, source bits 7..1 into bits 6..0, and bit 0 into carry.
// - With a file operand, direction 0 writes the accumulator and direction 1 writes back the file register.
// - Subtract from register computes register plus inverted accumulator plus carry and sets zero, digit carry, carry.
// - Subtract from immediate computes immediate plus inverted accumulator plus carry into the accumulator.
// - Zero is set for a zero result and carry is set when no borrow occurs.
// - Store to secondary page copies the accumulator into one of sixteen registers without touching flags.
// - Load from secondary page copies one of sixteen registers into the accumulator without touching flags.
// - Sleep pulses the watchdog clear output and halts execution, both in the same cycle.
// - Sleep sets the time-out flag to one and clears the power-down flag, leaving carry, zero and digit carry unchanged.
module rsx_exec (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic valid_in,
  input wire logic [2:0] op_in,
  input wire logic [5:0] file_addr_in,
  input wire logic [3:0] sfr_addr_in,
  input wire logic [7:0] imm_in,
  input wire logic dest_in,
  input wire logic wake_in,
  output logic [7:0] accumulator_out,
  output logic carry_flag_out,
  output logic zero_flag_out,
  output logic digit_carry_flag_out,
  output logic timeout_status_n_out,
  output logic powerdown_status_n_out,
  output logic watchdog_clear_out,
  output logic halt_out,
  output logic busy_out,
  output logic [7:0] file_rd_data_out,
  output logic [7:0] sfr_rd_data_out
);
  logic [7:0] acc_q, acc_d;
  logic c_q, c_d, z_q, z_d, dc_q, dc_d;
  logic to_n_q, to_n_d, pd_n_q, pd_n_d;
  logic wdt_clr_q, wdt_clr_d;
  rsx_pkg::rsx_state_t st_q, st_d;
  logic [7:0] file_q [rsx_pkg::FILE_DEPTH];
  logic [7:0] sfr_q [rsx_pkg::SFR_DEPTH];
  logic file_we, sfr_we;
  logic [7:0] file_wd;
  logic [7:0] fsrc, rot, sub_res, sub_min;
  logic sub_z, sub_dc, sub_c, run;

  assign run = valid_in && (st_q == rsx_pkg::RSX_RUN);
  assign fsrc = file_q[file_addr_in];
  assign rot = {c_q, fsrc[rsx_pkg::MSB:1]};
  assign sub_min = (op_in == rsx_pkg::SUB_BORROW_IMM_OP) ? imm_in : fsrc;

  rsx_sub_unit u_sub (
    .minuend_in(sub_min),
    .acc_in(acc_q),
    .carry_in(c_q),
    .result_out(sub_res),
    .zero_out(sub_z),
    .digit_carry_out(sub_dc),
    .carry_out(sub_c)
  );

  always_comb begin
    acc_d = acc_q;
    c_d = c_q;
    z_d = z_q;
    dc_d = dc_q;
    to_n_d = to_n_q;
    pd_n_d = pd_n_q;
    wdt_clr_d = 1'b0;
    st_d = st_q;
    file_we = 1'b0;
    file_wd = rot;
    sfr_we = 1'b0;
    if (st_q == rsx_pkg::RSX_HALT && wake_in) begin
      st_d = rsx_pkg::RSX_RUN;
    end
    if (run) begin
      unique case (op_in)
        rsx_pkg::ROTATE_RIGHT_CARRY_OP: begin
          c_d = fsrc[0];
          if (dest_in) begin
            file_we = 1'b1;
          end else begin
            acc_d = rot;
          end
        end
        rsx_pkg::SUB_BORROW_REG_OP: begin
          c_d = sub_c;
          z_d = sub_z;
          dc_d = sub_dc;
          file_wd = sub_res;
          if (dest_in) begin
            file_we = 1'b1;
          end else begin
            acc_d = sub_res;
          end
        end
        rsx_pkg::SUB_BORROW_IMM_OP: begin
          acc_d = sub_res;
          c_d = sub_c;
          z_d = sub_z;
          dc_d = sub_dc;
        end
        rsx_pkg::STORE_SECONDARY_PAGE_OP: begin
          sfr_we = 1'b1;
        end
        rsx_pkg::LOAD_SECONDARY_PAGE_OP: begin
          acc_d = sfr_q[sfr_addr_in];
        end
        rsx_pkg::SLEEP_OP: begin
          wdt_clr_d = 1'b1;
          to_n_d = 1'b1;
          pd_n_d = 1'b0;
          st_d = rsx_pkg::RSX_HALT;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_q <= rsx_pkg::ACC_RESET;
      c_q <= 1'b0;
      z_q <= 1'b0;
      dc_q <= 1'b0;
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
      wdt_clr_q <= 1'b0;
      st_q <= rsx_pkg::RSX_RUN;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      z_q <= z_d;
      dc_q <= dc_d;
      to_n_q <= to_n_d;
      pd_n_q <= pd_n_d;
      wdt_clr_q <= wdt_clr_d;
      st_q <= st_d;
    end
  end

  // File registers start cleared so that every read after reset is defined.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < rsx_pkg::FILE_DEPTH; i++) begin
        file_q[i] <= rsx_pkg::ZERO_BYTE;
      end
    end else if (file_we) begin
      file_q[file_addr_in] <= file_wd;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sfr_we) begin
      sfr_q[sfr_addr_in] <= acc_q;
    end
  end

  assign accumulator_out = acc_q;
  assign carry_flag_out = c_q;
  assign zero_flag_out = z_q;
  assign digit_carry_flag_out = dc_q;
  assign timeout_status_n_out = to_n_q;
  assign powerdown_status_n_out = pd_n_q;
  assign watchdog_clear_out = wdt_clr_q;
  assign halt_out = (st_q == rsx_pkg::RSX_HALT);
  assign busy_out = (st_q == rsx_pkg::RSX_HALT);
  assign file_rd_data_out = fsrc;
  assign sfr_rd_data_out = sfr_q[sfr_addr_in];

  property p_rotate;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::ROTATE_RIGHT_CARRY_OP && !dest_in)
      |=> (acc_q == {$past(c_q), $past(fsrc[7:1])} && c_q == $past(fsrc[0]));
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate result wrong");
  property p_dest;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::ROTATE_RIGHT_CARRY_OP && dest_in) |=> $stable(acc_q);
  endproperty
  a_dest: assert property (p_dest) else $error("accumulator written with direction one");
  property p_sub_reg;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::SUB_BORROW_REG_OP && !dest_in)
      |=> acc_q == 8'($past(fsrc) + ~$past(acc_q) + {7'h00, $past(c_q)});
  endproperty
  a_sub_reg: assert property (p_sub_reg) else $error("register subtract wrong");
  property p_sub_wb;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::SUB_BORROW_REG_OP && dest_in)
      |=> (file_q[$past(file_addr_in)] == 8'($past(fsrc) + ~$past(acc_q) + {7'h00, $past(c_q)}) && $stable(acc_q));
  endproperty
  a_sub_wb: assert property (p_sub_wb) else $error("register write-back wrong");
  property p_sub_imm;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::SUB_BORROW_IMM_OP)
      |=> acc_q == 8'($past(imm_in) + ~$past(acc_q) + {7'h00, $past(c_q)});
  endproperty
  a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong");
  property p_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::SUB_BORROW_IMM_OP) |=> (z_q == (acc_q == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_store;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::STORE_SECONDARY_PAGE_OP) |=> ($stable(c_q) && $stable(z_q) && $stable(dc_q));
  endproperty
  a_store: assert property (p_store) else $error("store changed flags");
  property p_load;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::LOAD_SECONDARY_PAGE_OP) |=> (acc_q == $past(sfr_rd_data_out) && $stable(c_q));
  endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_sleep;
    @(posedge clk_in) disable iff (!rst_n_in)
      (run && op_in == rsx_pkg::SLEEP_OP)
      |=> (watchdog_clear_out && halt_out && timeout_status_n_out && !powerdown_status_n_out && $stable(c_q));
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep effects wrong");
  c_rot: cover property (@(posedge clk_in) run && op_in == rsx_pkg::ROTATE_RIGHT_CARRY_OP);
  c_sub: cover property (@(posedge clk_in) run && op_in == rsx_pkg::SUB_BORROW_REG_OP && sub_z);
  c_rot_wb: cover property (@(posedge clk_in) run && op_in == rsx_pkg::ROTATE_RIGHT_CARRY_OP && dest_in);
  c_sleep: cover property (@(posedge clk_in) run && op_in == rsx_pkg::SLEEP_OP ##1 halt_out ##[1:20] !halt_out);
endmodule : rsx_exec
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the rotate, subtract and sleep executor.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic valid_in = 1'b0;
  logic [2:0] op_in = 3'h0;
  logic [5:0] file_addr_in = 6'h00;
  logic [3:0] sfr_addr_in = 4'h0;
  logic [7:0] imm_in = 8'h00;
  logic dest_in = 1'b0;
  logic wake_in = 1'b0;
  logic [7:0] acc, frd, srd;
  logic c, z, dc, to_n, pd_n, wdc, halt, busy;
  logic [7:0] m_acc = 8'h00;
  logic [2:0] m_flg = 3'h0;
  logic [7:0] e [16];
  logic [7:0] m_file [64];
  logic [8:0] sum;
  logic [4:0] lo;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 clk_in = ~clk_in;
  rsx_exec i_rsx_exec (.clk_in(clk_in), .rst_n_in(rst_n_in), .valid_in(valid_in), .op_in(op_in),
    .file_addr_in(file_addr_in), .sfr_addr_in(sfr_addr_in), .imm_in(imm_in), .dest_in(dest_in),
    .wake_in(wake_in), .accumulator_out(acc), .carry_flag_out(c), .zero_flag_out(z),
    .digit_carry_flag_out(dc), .timeout_status_n_out(to_n), .powerdown_status_n_out(pd_n),
    .watchdog_clear_out(wdc), .halt_out(halt), .busy_out(busy), .file_rd_data_out(frd),
    .sfr_rd_data_out(srd));
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Drives one instruction at the falling edge and returns at the next falling edge.
  task automatic issue(input logic [2:0] op, input logic [7:0] imm, input logic [3:0] sa, input logic v);
    valid_in = v;
    op_in = op;
    imm_in = imm;
    sfr_addr_in = sa;
    @(negedge clk_in);
  endtask : issue
  task automatic sub_imm(input logic [7:0] imm);
    sum = imm + {1'b0, ~m_acc} + m_flg[0];
    lo = imm[3:0] + {1'b0, ~m_acc[3:0]} + m_flg[0];
    m_acc = sum[7:0];
    m_flg = {lo[4], sum[7:0] == 8'h00, sum[8]};
    issue(rsx_pkg::SUB_BORROW_IMM_OP, imm, 4'h0, 1'b1);
    chk(acc, m_acc);
    chk({5'h00, dc, z, c}, {5'h00, m_flg});
  endtask : sub_imm
  // Runs one file-register instruction and checks accumulator, file register and flags against the model.
  task automatic file_op(input logic [2:0] op, input logic [5:0] fa, input logic d);
    logic [7:0] r;
    r = m_file[fa];
    if (op == rsx_pkg::ROTATE_RIGHT_CARRY_OP) begin
      sum = {r[0], m_flg[0], r[7:1]};
      m_flg[0] = sum[8];
    end else begin
      sum = r + {1'b0, ~m_acc} + m_flg[0];
      lo = r[3:0] + {1'b0, ~m_acc[3:0]} + m_flg[0];
      m_flg = {lo[4], sum[7:0] == 8'h00, sum[8]};
    end
    if (d) m_file[fa] = sum[7:0];
    else m_acc = sum[7:0];
    file_addr_in = fa;
    dest_in = d;
    issue(op, 8'h00, 4'h0, 1'b1);
    chk(acc, m_acc);
    chk(frd, m_file[fa]);
    chk({5'h00, dc, z, c}, {5'h00, m_flg});
  endtask : file_op
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    foreach (m_file[k]) m_file[k] = 8'h00;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk(acc, rsx_pkg::ACC_RESET);
    chk({1'b0, to_n, pd_n, halt, wdc, dc, z, c}, 8'h60);
    chk({7'h00, busy}, 8'h00);
    foreach (e[i]) sub_imm(8'h06 - 8'(i));
    sub_imm(8'hff);
    issue(rsx_pkg::SUB_BORROW_IMM_OP, 8'h55, 4'h0, 1'b0);
    chk(acc, m_acc);
    $display("test subtract done");
    for (int i = 0; i < 16; i++) begin
      sub_imm(8'(i * 37 + 9));
      e[i] = m_acc;
      issue(rsx_pkg::STORE_SECONDARY_PAGE_OP, 8'h00, 4'(i), 1'b1);
      chk(srd, e[i]);
      chk({5'h00, dc, z, c}, {5'h00, m_flg});
    end
    for (int i = 15; i >= 0; i--) begin
      sub_imm(8'h3c);
      issue(rsx_pkg::LOAD_SECONDARY_PAGE_OP, 8'h00, 4'(i), 1'b1);
      m_acc = e[i];
      chk(acc, e[i]);
      chk(srd, e[i]);
      chk({5'h00, dc, z, c}, {5'h00, m_flg});
    end
    $display("test secondary page done");
    file_op(rsx_pkg::SUB_BORROW_REG_OP, 6'h05, 1'b1);
    file_op(rsx_pkg::ROTATE_RIGHT_CARRY_OP, 6'h05, 1'b1);
    file_op(rsx_pkg::ROTATE_RIGHT_CARRY_OP, 6'h05, 1'b1);
    file_op(rsx_pkg::ROTATE_RIGHT_CARRY_OP, 6'h05, 1'b0);
    file_op(rsx_pkg::SUB_BORROW_REG_OP, 6'h05, 1'b0);
    file_op(rsx_pkg::SUB_BORROW_REG_OP, 6'h3f, 1'b1);
    file_op(rsx_pkg::ROTATE_RIGHT_CARRY_OP, 6'h3f, 1'b0);
    file_op(rsx_pkg::SUB_BORROW_REG_OP, 6'h00, 1'b0);
    $display("test file register done");
    issue(rsx_pkg::SLEEP_OP, 8'h00, 4'h0, 1'b1);
    chk({6'h00, wdc, halt}, 8'h03);
    chk({7'h00, busy}, 8'h01);
    chk({6'h00, to_n, pd_n}, 8'h02);
    chk({5'h00, dc, z, c}, {5'h00, m_flg});
    issue(rsx_pkg::SUB_BORROW_IMM_OP, 8'h77, 4'h0, 1'b1);
    chk(acc, m_acc);
    chk({6'h00, wdc, halt}, 8'h01);
    wake_in = 1'b1;
    issue(rsx_pkg::OP_NONE, 8'h00, 4'h0, 1'b0);
    wake_in = 1'b0;
    chk({6'h00, to_n, pd_n}, 8'h02);
    chk({6'h00, busy, halt}, 8'h00);
    sub_imm(8'h42);
    issue(rsx_pkg::OP_NONE, 8'h00, 4'h0, 1'b0);
    $display("test sleep done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
